// File: hdl/cpu_decode_defs.vh
// constants for the instruction decode and execute subset
`ifndef CPU_DECODE_DEFS_VH
`define CPU_DECODE_DEFS_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_DEBUG_BREAK     8'h00
`define OP_ATOMIC_LOCKOUT  8'h2F
`define OP_AND_RR          8'h52
`define OP_AND_RIR         8'h53
`define OP_AND_GG          8'h54
`define OP_AND_GIG         8'h55
`define OP_AND_GIM         8'h56
`define OP_AND_IGIM        8'h57
`define OP_EXTENDED_AND_EE 8'h58
`define OP_EXTENDED_AND_EI 8'h59
`define OP_CLEAR_DIRECT    8'hB0
`define OP_CLEAR_INDIRECT  8'hB1
`define OP_CALL_INDIRECT   8'hD4
`define OP_BIT_REVERSE     8'hD5
`define OP_CALL_DIRECT     8'hD6
`define OP_BIT_WRITE       8'hE2
`define OP_COMPLEMENT_CARRY 8'hEF
`define OP_BIT_TEST_JUMP_R 8'hF6
`define OP_BIT_TEST_JUMP_I 8'hF7

// ----------------------------------------
// flag bit positions
// ----------------------------------------
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4
`define FLAG_D 3
`define FLAG_H 2

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define PC_RESET       16'h0000
`define SP_RESET       12'h000
`define FLAGS_RESET    8'h00
`define LOCKOUT_COUNT  2'h3
`define ZERO_BYTE      8'h00
`define ZERO_NIBBLE    4'h0
`define ONE_COUNT3     3'h1
`define ONE_ADDR       12'h001
`define ONE_PC         16'h0001

// ----------------------------------------
// sequencer states
// ----------------------------------------
`define ST_FETCH   4'h0
`define ST_SRCP    4'h1
`define ST_SRC     4'h2
`define ST_DSTP    4'h3
`define ST_DST     4'h4
`define ST_PAIRHI  4'h5
`define ST_PAIRLO  4'h6
`define ST_PUSH1   4'h7
`define ST_PUSH2   4'h8
`define ST_WB      4'h9
`define ST_PAD     4'hA
`define ST_START   4'hF

`endif

// File: hdl/exec_unit.v
// combinational result, flag and branch logic for the subset
`include "cpu_decode_defs.vh"

module exec_unit (
	input  wire [7:0] opcode,
	input  wire [7:0] dstVal,
	input  wire [7:0] srcVal,
	input  wire [7:0] modByte,
	input  wire [7:0] flagsIn,
	output reg  [7:0] result,
	output reg  [7:0] flagsOut,
	output reg        wrEn,
	output reg        takeJump
);

	wire [2:0] bitSel;
	wire       pol;
	integer    i;

	assign bitSel = modByte[6:4];
	assign pol    = modByte[7];

	always @* begin
		result   = dstVal;
		flagsOut = flagsIn;
		wrEn     = 1'b0;
		takeJump = 1'b0;
		case (opcode)
			`OP_AND_RR, `OP_AND_RIR, `OP_AND_GG, `OP_AND_GIG, `OP_AND_GIM, `OP_AND_IGIM,
			`OP_EXTENDED_AND_EE, `OP_EXTENDED_AND_EI: begin
				result = dstVal & srcVal;
				wrEn   = 1'b1;
			end
			`OP_BIT_WRITE: begin
				result         = dstVal;
				result[bitSel] = pol;
				wrEn           = 1'b1;
			end
			`OP_BIT_REVERSE: begin
				for (i = 0; i < 8; i = i + 1) begin
					result[i] = dstVal[7 - i];
				end
				wrEn = 1'b1;
			end
			`OP_CLEAR_DIRECT, `OP_CLEAR_INDIRECT: begin
				result = `ZERO_BYTE;
				wrEn   = 1'b1;
			end
			`OP_BIT_TEST_JUMP_R, `OP_BIT_TEST_JUMP_I: begin
				takeJump = (srcVal[bitSel] == pol);
			end
			`OP_COMPLEMENT_CARRY: begin
				flagsOut[`FLAG_C] = ~flagsIn[`FLAG_C];
			end
			default: begin
				result = dstVal;
			end
		endcase
		// logic results: zero and sign from result, overflow cleared
		case (opcode)
			`OP_AND_RR, `OP_AND_RIR, `OP_AND_GG, `OP_AND_GIG, `OP_AND_GIM, `OP_AND_IGIM,
			`OP_EXTENDED_AND_EE, `OP_EXTENDED_AND_EI, `OP_BIT_WRITE, `OP_BIT_REVERSE: begin
				flagsOut[`FLAG_Z] = (result == `ZERO_BYTE);
				flagsOut[`FLAG_S] = result[7];
				flagsOut[`FLAG_V] = 1'b0;
			end
			default: begin
				flagsOut[`FLAG_V] = flagsOut[`FLAG_V];
			end
		endcase
	end

endmodule // exec_unit

// File: hdl/cpu_instruction_decode.v
// fetch, decode and execute sequencer for the instruction subset
`include "cpu_decode_defs.vh"

module cpu_instruction_decode (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        ce,
	input  wire [7:0]  progData,
	output reg  [15:0] progAddr,
	output reg         progRead,
	input  wire [7:0]  regRdData,
	input  wire [7:0]  workBase,
	output reg  [11:0] regAddr,
	output reg         regWr,
	output reg  [7:0]  regWrData,
	output reg  [7:0]  flags,
	output reg  [11:0] stackPtr,
	output reg         lockout,
	output reg         debugBreak,
	output reg         instrDone
);

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	function [2:0] fetchLen;
		input [7:0] op;
		begin
			case (op)
				`OP_AND_RR, `OP_AND_RIR, `OP_BIT_WRITE, `OP_BIT_REVERSE,
				`OP_CALL_INDIRECT, `OP_CLEAR_DIRECT, `OP_CLEAR_INDIRECT: fetchLen = 3'h2;
				`OP_AND_GG, `OP_AND_GIG, `OP_AND_GIM, `OP_AND_IGIM,
				`OP_BIT_TEST_JUMP_R, `OP_BIT_TEST_JUMP_I, `OP_CALL_DIRECT: fetchLen = 3'h3;
				`OP_EXTENDED_AND_EE, `OP_EXTENDED_AND_EI: fetchLen = 3'h4;
				default: fetchLen = 3'h1;
			endcase
		end
	endfunction

	function [2:0] execLen;
		input [7:0] op;
		begin
			case (op)
				`OP_DEBUG_BREAK: execLen = 3'h1;
				`OP_AND_RR, `OP_AND_GG, `OP_AND_GIM, `OP_EXTENDED_AND_EE,
				`OP_EXTENDED_AND_EI, `OP_BIT_TEST_JUMP_R, `OP_CALL_DIRECT,
				`OP_CLEAR_INDIRECT: execLen = 3'h3;
				`OP_AND_RIR, `OP_AND_GIG, `OP_AND_IGIM,
				`OP_BIT_TEST_JUMP_I: execLen = 3'h4;
				`OP_CALL_INDIRECT: execLen = 3'h6;
				default: execLen = 3'h2;
			endcase
		end
	endfunction

	function [11:0] workAddr;
		input [3:0] nib;
		begin
			workAddr = {workBase, nib};
		end
	endfunction

	// mode bits: srcInd srcRd dstInd dstRd callInd isCall
	function [3:0] stepAfter;
		input [3:0] cur;
		input [5:0] m;
		begin
			case (cur)
				`ST_START: stepAfter = m[5] ? `ST_SRCP : m[4] ? `ST_SRC : m[3] ? `ST_DSTP :
					m[2] ? `ST_DST : m[1] ? `ST_PAIRHI : m[0] ? `ST_PUSH1 : `ST_WB;
				`ST_SRCP:   stepAfter = `ST_SRC;
				`ST_SRC:    stepAfter = m[3] ? `ST_DSTP : m[2] ? `ST_DST : `ST_WB;
				`ST_DSTP:   stepAfter = m[2] ? `ST_DST : `ST_WB;
				`ST_DST:    stepAfter = `ST_WB;
				`ST_PAIRHI: stepAfter = `ST_PAIRLO;
				`ST_PAIRLO: stepAfter = `ST_PUSH1;
				`ST_PUSH1:  stepAfter = `ST_PUSH2;
				`ST_PUSH2:  stepAfter = `ST_WB;
				default:    stepAfter = `ST_WB;
			endcase
		end
	endfunction

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg  [1:0]  rstSync_r;
	wire        rstN;

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end
	assign rstN = rstSync_r[1];

	// ----------------------------------------
	// state and decode
	// ----------------------------------------
	reg  [3:0]  state_r;
	reg  [2:0]  fIdx_r;
	reg  [2:0]  execCnt_r;
	reg  [7:0]  op_r;
	reg  [7:0]  mod_r;
	reg  [7:0]  disp_r;
	reg  [5:0]  mode_r;
	reg  [11:0] srcA_r;
	reg  [11:0] dstA_r;
	reg  [7:0]  srcVal_r;
	reg  [7:0]  dstVal_r;
	reg  [15:0] target_r;
	reg  [1:0]  lockCnt_r;
	reg  [7:0]  b1_r;
	reg  [7:0]  b2_r;

	wire [7:0]  curOp;
	wire [7:0]  n1;
	wire [7:0]  n2;
	wire [7:0]  n3;
	wire        lastFetch;
	wire [7:0]  aluRes;
	wire [7:0]  aluFlags;
	wire        aluWr;
	wire        aluJump;
	wire        execEnd;
	wire [3:0]  nextStep;

	assign curOp     = (fIdx_r == 3'h0) ? progData : op_r;
	assign n1        = (fIdx_r == 3'h1) ? progData : b1_r;
	assign n2        = (fIdx_r == 3'h2) ? progData : b2_r;
	assign n3        = progData;
	assign lastFetch = (fIdx_r + `ONE_COUNT3) == fetchLen(curOp);
	assign execEnd   = (execCnt_r + `ONE_COUNT3) >= execLen(op_r);
	assign nextStep  = stepAfter(state_r, mode_r);

	// operand fields decoded as the last byte arrives
	reg  [5:0]  dMode;
	reg  [11:0] dSrc;
	reg  [11:0] dDst;
	reg  [7:0]  dImm;
	reg  [7:0]  dMod;
	reg  [7:0]  dDisp;
	reg  [15:0] dTgt;

	always @* begin
		dMode = 6'h00;
		dSrc  = {`ZERO_NIBBLE, n1};
		dDst  = {`ZERO_NIBBLE, n1};
		dImm  = n2;
		dMod  = n1;
		dDisp = n2;
		dTgt  = {n1, n2};
		case (curOp)
			`OP_AND_RR:  begin dMode = 6'h14; dSrc = workAddr(n1[3:0]); dDst = workAddr(n1[7:4]); end
			`OP_AND_RIR: begin dMode = 6'h34; dSrc = workAddr(n1[3:0]); dDst = workAddr(n1[7:4]); end
			`OP_AND_GG:  begin dMode = 6'h14; dDst = {`ZERO_NIBBLE, n2}; end
			`OP_AND_GIG: begin dMode = 6'h34; dDst = {`ZERO_NIBBLE, n2}; end
			`OP_AND_GIM: begin dMode = 6'h04; end
			`OP_AND_IGIM: begin dMode = 6'h0C; end
			`OP_EXTENDED_AND_EE: begin
				dMode = 6'h14;
				dSrc  = {n1, n2[7:4]};
				dDst  = {n2[3:0], n3};
			end
			`OP_EXTENDED_AND_EI: begin dMode = 6'h04; dImm = n1; dDst = {n2[3:0], n3}; end
			`OP_BIT_WRITE:   begin dMode = 6'h04; dDst = workAddr(n1[3:0]); end
			`OP_BIT_REVERSE: begin dMode = 6'h04; end
			`OP_BIT_TEST_JUMP_R: begin dMode = 6'h10; dSrc = workAddr(n1[3:0]); end
			`OP_BIT_TEST_JUMP_I: begin dMode = 6'h30; dSrc = workAddr(n1[3:0]); end
			`OP_CALL_INDIRECT:   begin dMode = 6'h03; end
			`OP_CALL_DIRECT:     begin dMode = 6'h01; end
			`OP_CLEAR_INDIRECT:  begin dMode = 6'h08; end
			default: begin dMode = 6'h00; end
		endcase
	end

	// address that each step finds on the register port
	reg  [11:0] stepAddr;
	always @* begin
		case (nextStep)
			`ST_SRC:    stepAddr = (state_r == `ST_SRCP) ? {`ZERO_NIBBLE, regRdData} : srcA_r;
			`ST_DST:    stepAddr = (state_r == `ST_DSTP) ? {`ZERO_NIBBLE, regRdData} : dstA_r;
			`ST_DSTP:   stepAddr = dstA_r;
			`ST_PAIRLO: stepAddr = srcA_r + `ONE_ADDR;
			default:    stepAddr = srcA_r;
		endcase
	end

	exec_unit uExec (
		.opcode   (op_r),
		.dstVal   (dstVal_r),
		.srcVal   (srcVal_r),
		.modByte  (mod_r),
		.flagsIn  (flags),
		.result   (aluRes),
		.flagsOut (aluFlags),
		.wrEn     (aluWr),
		.takeJump (aluJump)
	);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always @(posedge mclk or negedge rstN) begin
		if (!rstN) begin
			state_r <= `ST_FETCH;   fIdx_r <= 3'h0;       execCnt_r <= 3'h0;
			op_r <= `ZERO_BYTE;     mod_r <= `ZERO_BYTE;  disp_r <= `ZERO_BYTE;
			b1_r <= `ZERO_BYTE;     b2_r <= `ZERO_BYTE;   mode_r <= 6'h00;
			srcA_r <= 12'h000;      dstA_r <= 12'h000;    srcVal_r <= `ZERO_BYTE;
			dstVal_r <= `ZERO_BYTE; target_r <= `PC_RESET; lockCnt_r <= 2'h0;
			progAddr <= `PC_RESET;  progRead <= 1'b0;     regAddr <= 12'h000;
			regWr <= 1'b0;          regWrData <= `ZERO_BYTE; flags <= `FLAGS_RESET;
			stackPtr <= `SP_RESET;  lockout <= 1'b0;      debugBreak <= 1'b0;
			instrDone <= 1'b0;
		end else if (ce) begin
			regWr      <= 1'b0;
			debugBreak <= 1'b0;
			instrDone  <= 1'b0;
			progRead   <= 1'b0;
			execCnt_r  <= execCnt_r + `ONE_COUNT3;
			case (state_r)
				`ST_FETCH: begin
					progAddr <= progAddr + `ONE_PC;
					fIdx_r   <= fIdx_r + `ONE_COUNT3;
					progRead <= ~lastFetch;
					if (fIdx_r == 3'h0) op_r <= progData;
					if (fIdx_r == 3'h1) b1_r <= progData;
					if (fIdx_r == 3'h2) b2_r <= progData;
					if (lastFetch) begin
						op_r      <= curOp;
						mode_r    <= dMode;
						srcA_r    <= dSrc;
						dstA_r    <= dDst;
						srcVal_r  <= dImm;
						mod_r     <= dMod;
						disp_r    <= dDisp;
						target_r  <= dTgt;
						execCnt_r <= 3'h0;
						fIdx_r    <= 3'h0;
						state_r   <= stepAfter(`ST_START, dMode);
						regAddr   <= dMode[5] ? dSrc : dMode[4] ? dSrc : dDst;
					end
				end
				`ST_SRCP: begin
					srcA_r  <= {`ZERO_NIBBLE, regRdData};
					regAddr <= stepAddr;
					state_r <= nextStep;
				end
				`ST_SRC: begin
					srcVal_r <= regRdData;
					regAddr  <= stepAddr;
					state_r  <= nextStep;
				end
				`ST_DSTP: begin
					dstA_r  <= {`ZERO_NIBBLE, regRdData};
					regAddr <= stepAddr;
					state_r <= nextStep;
				end
				`ST_DST: begin
					dstVal_r <= regRdData;
					state_r  <= nextStep;
				end
				`ST_PAIRHI: begin
					target_r[15:8] <= regRdData;
					regAddr        <= stepAddr;
					state_r        <= nextStep;
				end
				`ST_PAIRLO: begin
					target_r[7:0] <= regRdData;
					state_r       <= nextStep;
				end
				`ST_PUSH1, `ST_PUSH2: begin
					stackPtr  <= stackPtr - `ONE_ADDR;
					regAddr   <= stackPtr - `ONE_ADDR;
					regWr     <= 1'b1;
					regWrData <= (state_r == `ST_PUSH1) ? progAddr[7:0] : progAddr[15:8];
					state_r   <= nextStep;
				end
				`ST_WB: begin
					flags <= aluFlags;
					if (aluWr) begin
						regAddr   <= dstA_r;
						regWr     <= 1'b1;
						regWrData <= aluRes;
					end
					if (aluJump) progAddr <= progAddr + {{8{disp_r[7]}}, disp_r};
					if (mode_r[0]) progAddr <= target_r;
					debugBreak <= (op_r == `OP_DEBUG_BREAK);
					state_r    <= execEnd ? `ST_FETCH : `ST_PAD;
					progRead   <= execEnd;
					instrDone  <= execEnd;
				end
				`ST_PAD: begin
					state_r   <= execEnd ? `ST_FETCH : `ST_PAD;
					progRead  <= execEnd;
					instrDone <= execEnd;
				end
				default: begin
					state_r <= `ST_FETCH;
				end
			endcase
			// lockout counts down on each instruction decoded after the atomic one
			if (state_r == `ST_FETCH && lastFetch) begin
				if (curOp == `OP_ATOMIC_LOCKOUT) begin
					lockCnt_r <= `LOCKOUT_COUNT;
					lockout   <= 1'b1;
				end else if (lockCnt_r != 2'h0) begin
					lockCnt_r <= lockCnt_r - 2'h1;
					lockout   <= 1'b1;
				end
			end else if ((state_r == `ST_WB || state_r == `ST_PAD) && execEnd) begin
				lockout <= (lockCnt_r != 2'h0);
			end
		end
	end

endmodule // cpu_instruction_decode

// File: dv/cpu_decode_checker_asserts.sv
// concurrent checks on the decode sequencer ports
module cpu_decode_checker (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic [7:0]  flags,
	input wire logic [11:0] stackPtr,
	input wire logic        lockout,
	input wire logic        debugBreak,
	input wire logic        instrDone
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	// retirements seen while requests are refused, own one included
	logic [2:0] doneCnt_r;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst)
			doneCnt_r <= 3'h0;
		else if (!lockout)
			doneCnt_r <= 3'h0;
		else if (instrDone && doneCnt_r != 3'h7)
			doneCnt_r <= doneCnt_r + 3'h1;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// every instruction takes a fetch and an exec, so at least six cycles
	sequence lockHold;
		lockout [*6];
	endsequence
	a_lock_hold: assert property ($rose(lockout) |-> lockHold)
		else $error("lockout released too early");
	a_lock_count: assert property ($fell(lockout) |-> doneCnt_r inside {3'h3, 3'h4})
		else $error("lockout dropped after wrong instruction count");
	a_sp_step: assert property ($changed(stackPtr)
		|-> 12'($past(stackPtr) - stackPtr) inside {12'h001, 12'h002})
		else $error("stack pointer moved other than down");
	a_no_overflow: assert property (flags[4] == 1'b0 && flags[1:0] == 2'h0)
		else $error("overflow or unused flag set");
	a_dh_kept: assert property ($stable(flags[3:2]))
		else $error("decimal or half carry changed");
	// flags land at write-back, which may precede the retire pulse by a pad cycle
	a_flags_retire: assert property ($changed(flags) |-> ##[0:1] instrDone)
		else $error("flags changed outside retirement");
	a_done_pulse: assert property (instrDone |=> !instrDone)
		else $error("retire pulse longer than one cycle");
	a_break_pulse: assert property (debugBreak |=> !debugBreak)
		else $error("break pulse longer than one cycle");
endmodule // cpu_decode_checker

bind cpu_instruction_decode cpu_decode_checker chk (
	.mclk(mclk), .nrst(nrst), .flags(flags), .stackPtr(stackPtr),
	.lockout(lockout), .debugBreak(debugBreak), .instrDone(instrDone));

// File: dv/prog_reg_model.sv
// program memory and register file beside the decoder
module prog_reg_model (
	input  wire logic        mclk,
	input  wire logic [15:0] progAddr,
	output wire logic [7:0]  progData,
	input  wire logic [11:0] regAddr,
	input  wire logic        regWr,
	input  wire logic [7:0]  regWrData,
	output wire logic [7:0]  regRdData
);
	timeunit 1ns;
	timeprecision 100ps;
	// small arrays: upper address bits alias, enough for this program
	logic [7:0] rom [0:255];
	logic [7:0] rf  [0:255];
	assign progData  = rom[progAddr[7:0]];
	assign regRdData = rf[regAddr[7:0]];
	always @(posedge mclk) begin
		if (regWr)
			rf[regAddr[7:0]] <= regWrData;
	end
endmodule // prog_reg_model

// File: dv/cpu_instruction_decode_test.sv
// self-checking bench running a short program through the decoder
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module cpu_instruction_decode_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        mclk, nrst, ce, progRead, regWr, lockout, debugBreak, instrDone;
	logic [7:0]  progData, regRdData, workBase, regWrData, flags;
	logic [15:0] progAddr;
	logic [11:0] regAddr, stackPtr;
	int          err_total = 0, total_checks = 0, cyc = 0, brkSeen = 0, i, k;
	// bytes at 0000 and 0001 left erased and run as one-byte instructions, real work starts at 0002
	logic [7:0]  prog [32] = '{8'hFF, 8'hFF, 8'hEF, 8'h52, 8'h12, 8'h58, 8'h02, 8'h00,
		8'h21, 8'hE2, 8'h83, 8'hE2, 8'h74, 8'hD5, 8'h15, 8'hB0, 8'h16, 8'hB1, 8'h17,
		8'h2F, 8'hEF, 8'hF6, 8'h81, 8'h02, 8'hF6, 8'h01, 8'h02, 8'hB0, 8'h19, 8'hD6,
		8'h00, 8'h40};
	logic [7:0]  flg [16] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'hA0, 8'h80, 8'h80, 8'hA0,
		8'hA0, 8'hA0, 8'hA0, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
	logic [7:0]  rfA [11] = '{8'h11, 8'h12, 8'h20, 8'h21, 8'h13, 8'h14, 8'h15, 8'h16,
		8'h17, 8'h18, 8'h19};
	logic [7:0]  rfV [11] = '{8'hF0, 8'h3C, 8'h81, 8'hC1, 8'h00, 8'hFF, 8'h01, 8'hAA,
		8'h18, 8'h55, 8'h77};

	cpu_instruction_decode uut (.mclk(mclk), .nrst(nrst), .ce(ce), .progData(progData),
		.progAddr(progAddr), .progRead(progRead), .regRdData(regRdData),
		.workBase(workBase), .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData),
		.flags(flags), .stackPtr(stackPtr), .lockout(lockout), .debugBreak(debugBreak),
		.instrDone(instrDone));
	prog_reg_model mem (.mclk(mclk), .progAddr(progAddr), .progData(progData),
		.regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData));

	// ----------------------------------------
	// clock, timeout and verdict
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (debugBreak === 1'b1)
			brkSeen++;
		if (cyc == 3000) begin
			err_total++;
			stop_test();
		end
	end
	// bounded wait for the next retirement pulse
	task automatic waitDone();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (instrDone !== 1'b1 && n < 40);
		if (n >= 40) `CHK("retire", 1'b1, instrDone)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		ce = 1'b1;
		workBase = 8'h01;
		for (k = 0; k < 256; k++) begin
			mem.rom[k] = 8'hFF;
			mem.rf[k] = 8'h00;
		end
		for (k = 0; k < 32; k++)
			mem.rom[k] = prog[k];
		mem.rom[8'h40] = 8'h00;
		for (k = 0; k < 11; k++)
			mem.rf[rfA[k]] = rfV[k];
		repeat (20) @(posedge mclk);
		#1 nrst = 1'b1;
		for (i = 0; i < 16; i++) begin
			waitDone();
			`CHK("flags", flg[i], flags)
			if (i >= 10 && i <= 12) `CHK("lockout on", 1'b1, lockout)
			if (i == 14) `CHK("lockout off", 1'b0, lockout)
		end
		$display("test flag walk done");
		repeat (4) @(posedge mclk);
		#1;
		`CHK("short and", 8'h30, mem.rf[8'h11])
		`CHK("extended and", 8'h81, mem.rf[8'h21])
		`CHK("bit set", 8'h01, mem.rf[8'h13])
		`CHK("bit clear", 8'h7F, mem.rf[8'h14])
		`CHK("bit reverse", 8'h80, mem.rf[8'h15])
		`CHK("clear direct", 8'h00, mem.rf[8'h16])
		`CHK("clear indirect", 8'h00, mem.rf[8'h18])
		`CHK("jump skipped", 8'h77, mem.rf[8'h19])
		`CHK("push low", 8'h20, mem.rf[8'hFF])
		`CHK("push high", 8'h00, mem.rf[8'hFE])
		`CHK("stack pointer", 12'hFFE, stackPtr)
		`CHK("break pulses", 1, brkSeen)
		$display("test result check done");
		stop_test();
	end
endmodule // cpu_instruction_decode_test
